// *** core/prwg_pkg.sv ***
// Constants for the protected register write guard.
// Assumes an APB master with 32-bit data on the register side.
package prwg_pkg;

  localparam int unsigned NUM_PROT = 6;

  // Printed offsets are register indices; byte address is four times.
  localparam logic [31:0] IDX_WAIT_CTRL   = 32'hfffff06e;
  localparam logic [31:0] IDX_STATUS      = 32'hfffff802;
  localparam logic [31:0] IDX_UNLOCK_CMD  = 32'hfffff0fc;
  localparam logic [31:0] IDX_PWR_SAVE    = 32'hfffff0f0;
  localparam logic [31:0] IDX_PROC_CLK    = 32'hfffff0f1;
  localparam logic [31:0] IDX_WDT_MODE    = 32'hfffff0f2;
  localparam logic [31:0] IDX_CLK_MON     = 32'hfffff0f3;
  localparam logic [31:0] IDX_RST_SRC     = 32'hfffff0f4;
  localparam logic [31:0] IDX_LOW_VOLT    = 32'hfffff0f5;

  localparam logic [31:0] PROT_IDX [NUM_PROT] = '{
    IDX_PWR_SAVE, IDX_PROC_CLK, IDX_WDT_MODE,
    IDX_CLK_MON, IDX_RST_SRC, IDX_LOW_VOLT
  };

  localparam logic [7:0]  WAIT_CTRL_RST   = 8'h77;
  localparam logic [7:0]  STATUS_RST      = 8'h00;
  localparam logic [7:0]  PROT_RST        = 8'h00;
  localparam int unsigned ERR_BIT         = 0;
  localparam int unsigned WAIT_LSB        = 0;
  localparam int unsigned WAIT_W          = 3;
  localparam logic [3:0]  STRB_BYTE0      = 4'h1;
  localparam int unsigned ACCESS_CLKS     = 3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_COUNT = 3'b010,
    ST_READY = 3'b100
  } prwg_state_e;

  function automatic logic [31:0] prwg_addr(input logic [31:0] idx);
    prwg_addr = {idx[29:0], 2'b00};
  endfunction : prwg_addr

endpackage : prwg_pkg

// *** core/prwg_top.sv ***
// Protected register write guard with APB register access.
// Assumes the CPU issues stores and loads as APB transfers and that a
// bit set, clear or invert arrives as an ordinary write of the new value.
//
// What this block does
// RL1: Six system registers are protected and need the unlock sequence.
// RL2: Only the first write after an unlock command reaches a protected register.
// RL3: Unlock command register is 8 bits, byte-write only, reads undefined.
// RL4: Any byte written to the unlock command arms the unlock.
// RL5: Interrupts are held off while the unlock is armed.
// RL6: Stores and bit operations alike consume the unlock.
// RL7: Software runs five no-operations after the protected write.
// RL8: Reads never need, consume or violate the unlock.
// RL9: Status register resets to zero; bit 0 is the error flag.
// RL10: Status register is readable and writable by byte or bit.
// RL11: Protected write without unlock sets the error flag.
// RL12: Armed write to an unprotected register sets the error flag.
// RL13: Reads between unlock and write neither cancel nor flag.
// RL14: Writing 0 or reset clears the error flag.
// RL15: Armed clearing write to the flag wins over the violation.
// RL16: Two unlock commands in a row set the error flag.
// RL17: Access takes three clocks plus the programmed wait clocks.
// RL18: Wait control register is 8 bits at its address, resets to 77h.
// RL19: Wait setting 00h adds no wait, 01h adds one.
// RL20: Software programs the wait control register first.
// RL21: Reset and any write after the unlock, except a refused narrow unlock command, disarm it.
`timescale 1ns/1ps
module prwg_top
  import prwg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic [7:0]       power_save_control,
  output logic [7:0]       processor_clock_control,
  output logic [7:0]       watchdog_mode_reg,
  output logic [7:0]       clock_monitor_mode,
  output logic [7:0]       reset_source_flags,
  output logic [7:0]       low_voltage_detect_reg,
  output logic [7:0]       peripheral_wait_control,
  output logic             protection_error_flag,
  output logic             intr_hold
);

  prwg_state_e       state;
  prwg_state_e       next_state;
  logic [WAIT_W-1:0] cnt;
  logic [7:0]        prot_q [NUM_PROT];
  logic              armed;

  wire logic [NUM_PROT-1:0] prot_hit;
  wire logic [2:0]          prot_idx;
  wire logic                is_prot;
  wire logic                is_cmd;
  wire logic                is_status;
  wire logic                is_wait;
  wire logic                mapped;
  wire logic                lane0;
  wire logic                cmd_bad;
  wire logic                access;
  wire logic                done;
  wire logic                wr;
  wire logic [WAIT_W-1:0]   wait_n;
  wire logic                cnt_end;
  wire logic [7:0]          rd_byte;
  wire logic                wr_ok;

  for (genvar i = 0; i < NUM_PROT; i++) begin : g_hit
    assign prot_hit[i] = (paddr == prwg_addr(PROT_IDX[i])); // RL1
  end

  function automatic logic [2:0] first_hit(input logic [NUM_PROT-1:0] h);
    first_hit = 3'h0;
    for (int j = NUM_PROT - 1; j >= 0; j--) begin
      if (h[j]) begin
        first_hit = 3'(j);
      end
    end
  endfunction : first_hit

  assign prot_idx  = first_hit(prot_hit);
  assign is_prot   = |prot_hit;
  assign is_cmd    = (paddr == prwg_addr(IDX_UNLOCK_CMD));
  assign is_status = (paddr == prwg_addr(IDX_STATUS));
  assign is_wait   = (paddr == prwg_addr(IDX_WAIT_CTRL)); // RL18
  assign mapped    = is_prot | is_cmd | is_status | is_wait;
  assign lane0     = pstrb[0];
  assign cmd_bad   = is_cmd & pwrite & (pstrb != STRB_BYTE0); // RL3
  assign access    = psel & penable;
  assign done      = access & (state == ST_READY);
  assign wr        = done & pwrite & ~cmd_bad; // RL8 RL13
  assign wr_ok     = wr & lane0;
  assign wait_n    = peripheral_wait_control[WAIT_LSB +: WAIT_W]; // RL19
  assign cnt_end   = (cnt == wait_n);

  // The command register reads as zero; its value is undefined by design.
  assign rd_byte = is_wait   ? peripheral_wait_control :
                   is_status ? {7'h00, protection_error_flag} : // RL9
                   is_prot   ? prot_q[prot_idx] : 8'h00;

  // Setup plus two access clocks with no wait; each wait adds one.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (access) begin
          next_state = (wait_n == '0) ? ST_READY : ST_COUNT; // RL17
        end
      end
      ST_COUNT: begin
        if (cnt_end) begin
          next_state = ST_READY; // RL17
        end
      end
      ST_READY: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      cnt     <= '0;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= (state == ST_IDLE) ? WAIT_W'(1) : cnt + WAIT_W'(1);
      pready  <= (next_state == ST_READY);
      prdata  <= (next_state == ST_READY && !pwrite) ? {24'h0, rd_byte}
                                                     : 32'h0000_0000;
      pslverr <= (next_state == ST_READY) & (~mapped | cmd_bad);
    end
  end

  // Any write but a refused narrow unlock command disarms, so a stray store cannot leave the lock open.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (wr) begin
      armed <= ~armed & is_cmd; // RL2 RL4 RL21
    end
  end

  // Reads leave the lock and flag alone, whatever they target.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      protection_error_flag <= STATUS_RST[ERR_BIT]; // RL9 RL14
    end else if (wr) begin
      if (armed) begin
        if (is_status && lane0 && !pwdata[ERR_BIT]) begin
          protection_error_flag <= 1'b0; // RL15
        end else if (!is_prot) begin
          protection_error_flag <= 1'b1; // RL12 RL16
        end
      end else if (is_prot) begin
        protection_error_flag <= 1'b1; // RL11
      end else if (is_status && lane0) begin
        protection_error_flag <= pwdata[ERR_BIT]; // RL10 RL14
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_wait_control <= WAIT_CTRL_RST; // RL18
    end else if (wr_ok && is_wait) begin
      peripheral_wait_control <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_PROT; k++) begin
        prot_q[k] <= PROT_RST;
      end
    end else if (wr_ok && armed && is_prot) begin
      prot_q[prot_idx] <= pwdata[7:0]; // RL2 RL6
    end
  end

  // Held interrupts let the command and protected store run back to back.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      intr_hold <= 1'b0;
    end else if (wr) begin
      intr_hold <= ~armed & is_cmd; // RL5
    end
  end

  assign power_save_control      = prot_q[0];
  assign processor_clock_control = prot_q[1];
  assign watchdog_mode_reg       = prot_q[2];
  assign clock_monitor_mode      = prot_q[3];
  assign reset_source_flags      = prot_q[4];
  assign low_voltage_detect_reg  = prot_q[5];

  sequence s_setup_nowait;
    psel && !penable && wait_n == '0 && state == ST_IDLE;
  endsequence

  sequence s_setup_onewait;
    psel && !penable && wait_n == WAIT_W'(1) && state == ST_IDLE;
  endsequence

  a_access_nowait: assert property ( // RL17
    @(posedge core_clk) disable iff (!rst_n)
    s_setup_nowait ##1 psel && penable |-> !pready ##1 pready)
    else $error("no-wait access did not take three clocks");

  a_access_onewait: assert property ( // RL19
    @(posedge core_clk) disable iff (!rst_n)
    s_setup_onewait ##1 psel && penable |-> !pready [*2] ##1 pready)
    else $error("one-wait access did not take four clocks");

  a_cmd_arms: assert property ( // RL4
    @(posedge core_clk) disable iff (!rst_n)
    wr && is_cmd && !armed |=> armed && intr_hold)
    else $error("unlock command did not arm");

  a_double_cmd: assert property ( // RL16
    @(posedge core_clk) disable iff (!rst_n)
    wr && is_cmd && armed |=> protection_error_flag && !armed)
    else $error("second unlock command not flagged");

  a_prot_reject: assert property ( // RL11
    @(posedge core_clk) disable iff (!rst_n)
    wr && is_prot && !armed
    |=> protection_error_flag && prot_q[$past(prot_idx)] ==
        $past(prot_q[prot_idx]))
    else $error("unguarded protected write was not rejected");

  a_prot_accept: assert property ( // RL2
    @(posedge core_clk) disable iff (!rst_n)
    wr_ok && is_prot && armed
    |=> prot_q[$past(prot_idx)] == $past(pwdata[7:0]) && !armed)
    else $error("armed protected write was not stored");

  a_clear_wins: assert property ( // RL15
    @(posedge core_clk) disable iff (!rst_n)
    wr && armed && is_status && lane0 && !pwdata[ERR_BIT]
    |=> !protection_error_flag)
    else $error("clearing write lost to violation");

  a_other_flags: assert property ( // RL12
    @(posedge core_clk) disable iff (!rst_n)
    wr && armed && is_wait |=> protection_error_flag)
    else $error("armed unprotected write not flagged");

  a_read_keeps: assert property ( // RL8
    @(posedge core_clk) disable iff (!rst_n)
    done && !pwrite |=> $stable(armed) && $stable(protection_error_flag))
    else $error("read changed unlock or error state");

  a_status_zero: assert property ( // RL9
    @(posedge core_clk) disable iff (!rst_n)
    pready && !pslverr && $past(is_status) && $past(!pwrite)
    |-> prdata[31:1] == 31'h0)
    else $error("status upper bits not zero");

  // The six protected bytes side by side, so one check can watch them all.
  wire logic [8*NUM_PROT-1:0] prot_bus;

  assign prot_bus = {power_save_control, processor_clock_control,
                     watchdog_mode_reg, clock_monitor_mode,
                     reset_source_flags, low_voltage_detect_reg};

  // Armed and plain writes take different paths through the flag logic,
  // so the checks below name each path once and build on it.
  sequence s_armed_write;
    wr && armed;
  endsequence

  sequence s_plain_status;
    wr && !armed && is_status && lane0;
  endsequence

  sequence s_bad_cmd_done;
    done && cmd_bad;
  endsequence

  a_bad_cmd: assert property ( // RL3
    @(posedge core_clk) disable iff (!rst_n)
    s_bad_cmd_done |-> pslverr ##1
      ($stable(armed) && $stable(protection_error_flag)))
    else $error("narrow unlock command was not refused");

  a_unmapped_err: assert property ( // RL12
    @(posedge core_clk) disable iff (!rst_n)
    done && !mapped |-> pslverr)
    else $error("unmapped access gave no slave error");

  a_ready_pulse: assert property ( // RL17
    @(posedge core_clk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("ready stood for more than one clock");

  a_state_onehot: assert property ( // RL17
    @(posedge core_clk) disable iff (!rst_n)
    $onehot(state))
    else $error("access state left its one-hot codes");

  a_count_bound: assert property ( // RL19
    @(posedge core_clk) disable iff (!rst_n)
    state == ST_COUNT |-> cnt != '0 && cnt <= wait_n)
    else $error("wait counter ran past the setting");

  a_wait_store: assert property ( // RL18
    @(posedge core_clk) disable iff (!rst_n)
    wr_ok && is_wait |=> peripheral_wait_control == $past(pwdata[7:0]))
    else $error("wait control write was lost");

  a_status_write: assert property ( // RL10
    @(posedge core_clk) disable iff (!rst_n)
    s_plain_status |=> protection_error_flag == $past(pwdata[ERR_BIT]))
    else $error("status write did not reach the error flag");

  a_hold_armed: assert property ( // RL5
    @(posedge core_clk) disable iff (!rst_n)
    intr_hold == armed)
    else $error("interrupt hold does not follow the unlock");

  a_any_disarm: assert property ( // RL21
    @(posedge core_clk) disable iff (!rst_n)
    s_armed_write |=> !armed && !intr_hold)
    else $error("write after unlock left it armed");

  a_prot_hold: assert property ( // RL2
    @(posedge core_clk) disable iff (!rst_n)
    !(wr_ok && armed && is_prot) |=> $stable(prot_bus))
    else $error("protected register changed without an unlock");

  a_lane_skip: assert property ( // RL2
    @(posedge core_clk) disable iff (!rst_n)
    wr && !lane0 |=> $stable(prot_bus) && $stable(peripheral_wait_control))
    else $error("write without the low lane stored a byte");

endmodule : prwg_top

// *** verif/prwg_cpu_model.sv ***
// CPU core model issuing register loads and stores as APB transfers.
// Assumes one clock shared with the guard and a slave that answers.
`timescale 1ns/1ps
module prwg_cpu_model
  import prwg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
  end

  // The unlock store is followed at once by the next store, so the guard
  // never sees an instruction slip in between.
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic er,
                      output int n);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
    // Released lines show the inverse so stale data is never mistaken.
    if (w && a != {IDX_UNLOCK_CMD[29:0], 2'b00}) begin
      repeat (5) @(posedge core_clk);
    end
  endtask : xfer
endmodule : prwg_cpu_model

// *** verif/prwg_top_test.sv ***
// Self-checking bench for the protected register write guard.
// Assumes the CPU model drives the APB side; all outputs are watched here.
`timescale 1ns/1ps
module prwg_top_test
  import prwg_pkg::*;
();
  typedef struct {logic w; logic [31:0] i; logic [7:0] d; logic [3:0] s;
                  logic [7:0] x; logic e; logic f;} prwg_row_s;
  localparam logic [31:0] C  = IDX_UNLOCK_CMD;
  localparam logic [31:0] S  = IDX_STATUS;
  localparam logic [31:0] W  = IDX_WAIT_CTRL;
  localparam logic [31:0] U  = 32'h00000100;
  localparam logic [31:0] P0 = PROT_IDX[0];
  localparam logic [31:0] P1 = PROT_IDX[1];
  localparam logic [31:0] P2 = PROT_IDX[2];
  localparam logic [31:0] P3 = PROT_IDX[3];
  localparam logic [31:0] P4 = PROT_IDX[4];
  localparam logic [31:0] P5 = PROT_IDX[5];
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        protection_error_flag, intr_hold, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  power_save_control, processor_clock_control;
  logic [7:0]  watchdog_mode_reg, clock_monitor_mode;
  logic [7:0]  reset_source_flags, low_voltage_detect_reg;
  logic [7:0]  peripheral_wait_control;
  int          n, wt, err_total, checks;
  prwg_row_s   rows [35] = '{
    '{0, W, 8'h0, 4'h1, 8'h77, 0, 0},
    '{1, W, 8'h0, 4'h1, 8'h0, 0, 0},
    '{0, S, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, P0, 8'h5a, 4'h1, 8'h0, 0, 1},
    '{1, S, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'ha5, 4'h1, 8'h0, 0, 0},
    '{0, W, 8'h0, 4'h1, 8'h0, 0, 0},
    '{0, P0, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, P0, 8'h11, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, P1, 8'h22, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'hff, 4'h1, 8'h0, 0, 0},
    '{1, P2, 8'h33, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'h5a, 4'h1, 8'h0, 0, 0},
    '{1, P3, 8'h44, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'h01, 4'h1, 8'h0, 0, 0},
    '{1, P4, 8'h55, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'h80, 4'h1, 8'h0, 0, 0},
    '{1, P5, 8'h66, 4'h1, 8'h0, 0, 0},
    '{1, P5, 8'h99, 4'h1, 8'h0, 0, 1},
    '{1, S, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'h0, 4'h1, 8'h0, 0, 1},
    '{1, S, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, W, 8'h0, 4'h1, 8'h0, 0, 1},
    '{1, C, 8'h0, 4'h1, 8'h0, 0, 1},
    '{1, S, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'h0, 4'h2, 8'h0, 1, 0},
    '{1, P0, 8'h77, 4'h1, 8'h0, 0, 1},
    '{1, S, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, C, 8'h0, 4'h1, 8'h0, 0, 0},
    '{1, U, 8'h0, 4'h1, 8'h0, 1, 1},
    '{1, S, 8'h01, 4'h1, 8'h0, 0, 1},
    '{0, S, 8'h0, 4'h1, 8'h01, 0, 1}};

  prwg_top dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .power_save_control,
    .processor_clock_control, .watchdog_mode_reg, .clock_monitor_mode,
    .reset_source_flags, .low_voltage_detect_reg, .peripheral_wait_control,
    .protection_error_flag, .intr_hold);
  prwg_cpu_model cpu (.core_clk, .pready, .prdata, .pslverr, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb);

  function automatic logic [31:0] ba(input logic [31:0] i);
    ba = i << 2;
  endfunction : ba

  task automatic chk(string nm, logic [63:0] s, logic [63:0] x);
    checks++;
    if (s !== x) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, x, s);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // The whole run needs well under ten microseconds.
  initial begin
    #100000;
    err_total++;
    $display("watchdog expired");
    results();
  end

  initial begin
    rst_n = 1'b0;
    wt = WAIT_CTRL_RST[WAIT_W-1:0];
    repeat (10) @(posedge core_clk);
    chk("wait_rst", peripheral_wait_control, 8'h77);
    chk("flag_rst", protection_error_flag, 1'b0);
    rst_n <= 1'b1;
    foreach (rows[k]) begin
      cpu.xfer(rows[k].w, ba(rows[k].i), {24'h0, rows[k].d}, rows[k].s,
               rd, er, n);
      #1;
      if (!rows[k].w) chk("rdata", rd, {24'h0, rows[k].x});
      chk("pslverr", er, rows[k].e);
      chk("flag", protection_error_flag, rows[k].f);
      chk("cycles", n, ACCESS_CLKS + wt);
      if (rows[k].w && rows[k].i == W) wt = rows[k].d[2:0];
    end
    chk("prot", {power_save_control, processor_clock_control,
        watchdog_mode_reg, clock_monitor_mode, reset_source_flags,
        low_voltage_detect_reg}, 48'h112233445566);
    $display("table done");
    cpu.xfer(1'b1, ba(C), 32'h3c, 4'h1, rd, er, n);
    #1;
    chk("hold_on", intr_hold, 1'b1);
    cpu.xfer(1'b1, ba(P0), 32'h0f, 4'h1, rd, er, n);
    #1;
    chk("hold_off", intr_hold, 1'b0);
    chk("power_save", power_save_control, 8'h0f);
    cpu.xfer(1'b1, ba(C), 32'h3c, 4'h1, rd, er, n);
    cpu.xfer(1'b1, ba(P1), 32'hee, 4'h2, rd, er, n);
    #1;
    chk("lane_skip", processor_clock_control, 8'h22);
    chk("lane_disarm", intr_hold, 1'b0);
    cpu.xfer(1'b1, ba(W), 32'h01, 4'h1, rd, er, n);
    cpu.xfer(1'b0, ba(S), 32'h0, 4'h1, rd, er, n);
    chk("wait1", n, ACCESS_CLKS + 1);
    $display("unlock and wait done");
    cpu.xfer(1'b1, ba(C), 32'h0, 4'h1, rd, er, n);
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("flag_rst2", protection_error_flag, 1'b0);
    chk("wait_rst2", peripheral_wait_control, 8'h77);
    chk("hold_rst", intr_hold, 1'b0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    cpu.xfer(1'b0, ba(W), 32'h0, 4'h1, rd, er, n);
    chk("wait_rd", rd, {24'h0, WAIT_CTRL_RST});
    chk("wait_cyc", n, ACCESS_CLKS + WAIT_CTRL_RST[WAIT_W-1:0]);
    cpu.xfer(1'b1, ba(P0), 32'h5a, 4'h1, rd, er, n);
    #1;
    chk("disarm_rst", protection_error_flag, 1'b1);
    chk("reject_rst", power_save_control, PROT_RST);
    $display("reset done");
    results();
  end
endmodule : prwg_top_test
